// ---- sbt_pkg.sv ----
// shared constants and types of the serial transmitter with baud divisor
package sbt_pkg;
	localparam int         AXI_AW       = 8;
	localparam logic [7:0] OFF_DIV_HI   = 8'h00;
	localparam logic [7:0] OFF_DIV_LO   = 8'h04;
	localparam logic [7:0] OFF_CTRL     = 8'h08;
	localparam logic [7:0] OFF_STAT     = 8'h0c;
	localparam logic [7:0] OFF_IRQ_ST   = 8'h10;
	localparam logic [7:0] OFF_IRQ_MSK  = 8'h14;
	localparam logic [7:0] OFF_DATA_HI  = 8'h18;
	localparam logic [7:0] OFF_DATA_LO  = 8'h1c;
	localparam int         DIV_W        = 13;
	localparam int         DIV_HI_W     = 5;
	localparam logic [12:0] DIV_RST     = 13'h0000;
	localparam logic [4:0] DIV_HI_RST   = 5'h00;
	localparam int         CTRL_TX_ON   = 0;
	localparam int         CTRL_RX_ON   = 1;
	localparam int         CTRL_NINE    = 4;
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam int         STAT_TX_BUFFER_EMPTY_FLAG    = 0;
	localparam int         STAT_TX_BUSY = 1;
	localparam int         STAT_RX_BUSY = 2;
	localparam int         STAT_GEN_RUN = 3;
	localparam int         EV_TX_BUFFER_EMPTY_FLAG      = 0;
	localparam int         EV_TX_DONE   = 1;
	localparam int         EV_START     = 2;
	localparam int         EV_REJECT    = 3;
	localparam int         EV_NOISE     = 4;
	localparam int         EV_W         = 5;
	localparam logic [4:0] EV_RST       = 5'h00;
	localparam logic [3:0] RT_LAST      = 4'hf;
	localparam logic [3:0] RT_A         = 4'h2;
	localparam logic [3:0] RT_B         = 4'h4;
	localparam logic [3:0] RT_C         = 4'h6;
	localparam logic [3:0] RT_MID       = 4'h7;
	localparam logic [3:0] BITS_8       = 4'ha;
	localparam logic [3:0] BITS_9       = 4'hb;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	typedef enum logic [1:0] {
		RX_HUNT   = 2'b00,
		RX_VERIFY = 2'b01,
		RX_FRAME  = 2'b10
	} sbt_rx_state_t;
	typedef enum logic [0:0] {
		TX_IDLE  = 1'b0,
		TX_SHIFT = 1'b1
	} sbt_tx_state_t;
endpackage : sbt_pkg

// ---- sbt_tick_if.sv ----
// oversample tick shared by the transmitter and the receiver
`timescale 1ns/1ps
interface sbt_tick_if;
	logic tick16;
	modport gen  (output tick16);
	modport user (input  tick16);
endinterface : sbt_tick_if

// ---- sbt_baud.sv ----
// baud generator: one tick every divisor clocks, sixteen ticks per bit
`timescale 1ns/1ps
module sbt_baud
	import sbt_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             run,
	sbt_tick_if.gen               tk
);
	logic [DIV_W-1:0] cnt_ff;
	logic             tick_ff;
	wire              wrap = (cnt_ff >= divisor - 13'h0001);

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin // [R5] [R6]
			cnt_ff  <= DIV_RST;
			tick_ff <= 1'b0;
		end else if (wrap) begin // [R1]
			cnt_ff  <= DIV_RST;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + 13'h0001;
			tick_ff <= 1'b0;
		end
	end

	assign tk.tick16 = tick_ff;
endmodule : sbt_baud

// ---- sbt_rx_start.sv ----
// receiver start-bit search and verification with frame tracking
`timescale 1ns/1ps
module sbt_rx_start
	import sbt_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic enable,
	input  wire logic nine,
	input  wire logic rxd,
	sbt_tick_if.user  tk,
	output logic      start_found,
	output logic      rejected,
	output logic      noise_hit,
	output logic      busy
);
	sbt_rx_state_t state_ff;
	logic [3:0]    rt_ff;
	logic [3:0]    bit_ff;
	logic          seen_hi_ff;
	logic          s_a_ff;
	logic          s_b_ff;
	logic          found_ff;
	logic          rej_ff;
	logic          noise_ff;
	wire  [1:0]    lows = {1'b0, ~s_a_ff} + {1'b0, ~s_b_ff} + {1'b0, ~rxd};
	wire  [3:0]    last_bit = nine ? BITS_9 : BITS_8;

	always_ff @(posedge aclk) begin
		found_ff <= 1'b0;
		rej_ff   <= 1'b0;
		noise_ff <= 1'b0;
		if (!aresetn || !enable) begin
			state_ff   <= RX_HUNT;
			rt_ff      <= 4'h0;
			bit_ff     <= 4'h0;
			seen_hi_ff <= 1'b0;
			s_a_ff     <= 1'b1;
			s_b_ff     <= 1'b1;
		end else if (tk.tick16) begin
			rt_ff <= rt_ff + 4'h1; // [R16]
			case (state_ff)
				RX_HUNT: begin
					seen_hi_ff <= rxd;
					rt_ff      <= 4'h0;
					if (seen_hi_ff && !rxd) state_ff <= RX_VERIFY;
				end
				RX_VERIFY: begin
					if (rt_ff + 4'h1 == RT_A) s_a_ff <= rxd;
					if (rt_ff + 4'h1 == RT_B) begin
						s_b_ff <= rxd;
						if (s_a_ff && rxd) begin // [R13] [R14]
							state_ff   <= RX_HUNT;
							seen_hi_ff <= 1'b1;
							rej_ff     <= 1'b1;
						end
					end
					if (rt_ff + 4'h1 == RT_C) begin
						if (lows >= 2'h2) begin
							state_ff <= RX_FRAME;
							bit_ff   <= 4'h0;
							found_ff <= 1'b1;
							noise_ff <= (lows != 2'h3);
						end else begin // [R14]
							state_ff   <= RX_HUNT;
							seen_hi_ff <= 1'b1;
							rej_ff     <= 1'b1;
						end
					end
				end
				RX_FRAME: begin
					if (rt_ff == RT_LAST) bit_ff <= bit_ff + 4'h1;
					if (bit_ff == last_bit - 4'h1 && rt_ff == RT_MID) begin
						state_ff   <= RX_HUNT;
						seen_hi_ff <= 1'b0;
					end
				end
				default: state_ff <= RX_HUNT;
			endcase
		end
	end

	assign start_found = found_ff;
	assign rejected    = rej_ff;
	assign noise_hit   = noise_ff;
	assign busy        = (state_ff != RX_HUNT);
endmodule : sbt_rx_start

// ---- sbt_top.sv ----
// serial transmitter with baud divisor, start-bit check and axi4-lite registers
//
// How it works
// (R1) the bit rate is the module clock divided by sixteen times the divisor.
// (R2) software programs the thirteen-bit divisor between 1 and 8191 over the high and low registers.
// (R3) a high-register write waits in a holding register until the low register is written.
// (R4) after only a high write, divisor reads show the old value until the low write.
// (R5) the baud generator stays off after reset until tx_on or rx_on is first set.
// (R6) the baud generator is stopped while the divisor is zero.
// (R7) transmitter and receiver run independently from the one shared baud generator.
// (R8) the nine-bit control bit selects eight or nine data bits per character.
// (R9) in nine-bit mode ninth_tx_bit is sent as data bit 8.
// (R10) buffered data moves to the shifter and goes out between a start and a stop bit.
// (R11) the data registers are write-only buffers in front of the shifter.
// (R12) the buffer-empty flag is set when a character moves into the shifter, except in a cycle that also writes the data low buffer.
// (R13) if the third and fifth verification samples are high the search restarts.
// (R14) noise rejected before a start bit is confirmed raises no noise event.
// (R15) the line idles high, start is low, data goes lsb first, stop is high.
// (R16) the receiver counts sixteen ticks per bit from the first low it sees.
`timescale 1ns/1ps
module sbt_top
	import sbt_pkg::*;
#(
	parameter int AW = AXI_AW
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               txd,
	input  wire logic          rxd,
	output logic               irq
);
	import sbt_pkg::*;

	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
		hit = (a == AW'(off));
	endfunction : hit

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = hit(a, OFF_DIV_HI) || hit(a, OFF_DIV_LO) || hit(a, OFF_CTRL)
			|| hit(a, OFF_STAT) || hit(a, OFF_IRQ_ST) || hit(a, OFF_IRQ_MSK)
			|| hit(a, OFF_DATA_HI) || hit(a, OFF_DATA_LO);
	endfunction : mapped

	// write channel holding
	logic          aw_hold_ff;
	logic [AW-1:0] awaddr_ff;
	logic          w_hold_ff;
	logic [31:0]   wdata_ff;
	logic          wlane_ff;
	logic          bvalid_ff;
	logic [1:0]    bresp_ff;
	// read channel
	logic          rvalid_ff;
	logic [31:0]   rdata_ff;
	logic [1:0]    rresp_ff;
	logic [31:0]   rd_word;

	// registers
	logic [DIV_HI_W-1:0] div_hi_tmp_ff;
	logic [DIV_W-1:0]    divisor_ff;
	logic [7:0]          ctrl_ff;
	logic [EV_W-1:0]     irq_st_ff;
	logic [EV_W-1:0]     irq_msk_ff;
	logic                ninth_ff;
	logic [7:0]          data_lo_ff;
	logic                tx_buffer_empty_flag_ff;
	logic                gen_armed_ff;

	// transmitter
	sbt_tx_state_t tx_state_ff;
	logic [10:0]   shift_ff;
	logic [3:0]    bits_left_ff;
	logic [3:0]    tx_rt_ff;
	logic          txd_ff;

	// receiver pin synchroniser
	logic rxd_meta_ff;
	logic rxd_sync_ff;

	logic rx_found;
	logic rx_rejected;
	logic rx_noise;
	logic rx_busy;

	sbt_tick_if tk ();

	// ---------------- bus decode
	wire aw_take  = s_axi_awvalid && !aw_hold_ff;
	wire w_take   = s_axi_wvalid && !w_hold_ff;
	wire wr_go    = aw_hold_ff && w_hold_ff && !bvalid_ff;
	wire wr_ok    = wr_go && mapped(awaddr_ff);
	wire wr_en    = wr_ok && wlane_ff;
	wire ar_take  = s_axi_arvalid && !rvalid_ff;

	wire wr_div_hi  = wr_en && hit(awaddr_ff, OFF_DIV_HI);
	wire wr_div_lo  = wr_en && hit(awaddr_ff, OFF_DIV_LO);
	wire wr_ctrl    = wr_en && hit(awaddr_ff, OFF_CTRL);
	wire wr_irq_st  = wr_en && hit(awaddr_ff, OFF_IRQ_ST);
	wire wr_irq_msk = wr_en && hit(awaddr_ff, OFF_IRQ_MSK);
	wire wr_data_hi = wr_en && hit(awaddr_ff, OFF_DATA_HI);
	wire wr_data_lo = wr_en && hit(awaddr_ff, OFF_DATA_LO);

	wire [7:0] wbyte = wdata_ff[7:0];

	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready  = !w_hold_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// ---------------- bus slave, write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			awaddr_ff  <= '0;
		end else if (aw_take) begin
			aw_hold_ff <= 1'b1;
			awaddr_ff  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_ff <= 1'b0;
			wdata_ff  <= 32'h0000_0000;
			wlane_ff  <= 1'b0;
		end else if (w_take) begin
			w_hold_ff <= 1'b1;
			wdata_ff  <= s_axi_wdata;
			wlane_ff  <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ---------------- bus slave, read side
	wire gen_run = gen_armed_ff && (divisor_ff != DIV_RST); // [R5] [R6]
	wire tx_busy = (tx_state_ff == TX_SHIFT);

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit(s_axi_araddr, OFF_DIV_HI)) begin
			rd_word[DIV_HI_W-1:0] = divisor_ff[DIV_W-1:8]; // [R4]
		end else if (hit(s_axi_araddr, OFF_DIV_LO)) begin
			rd_word[7:0] = divisor_ff[7:0];
		end else if (hit(s_axi_araddr, OFF_CTRL)) begin
			rd_word[7:0] = ctrl_ff;
		end else if (hit(s_axi_araddr, OFF_STAT)) begin
			rd_word[STAT_TX_BUFFER_EMPTY_FLAG]    = tx_buffer_empty_flag_ff;
			rd_word[STAT_TX_BUSY] = tx_busy;
			rd_word[STAT_RX_BUSY] = rx_busy;
			rd_word[STAT_GEN_RUN] = gen_run;
		end else if (hit(s_axi_araddr, OFF_IRQ_ST)) begin
			rd_word[EV_W-1:0] = irq_st_ff;
		end else if (hit(s_axi_araddr, OFF_IRQ_MSK)) begin
			rd_word[EV_W-1:0] = irq_msk_ff;
		end
		// data buffers are write-only and read as zero [R11]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ---------------- divisor and control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_hi_tmp_ff <= DIV_HI_RST;
			divisor_ff    <= DIV_RST;
		end else begin
			if (wr_div_hi) div_hi_tmp_ff <= wbyte[DIV_HI_W-1:0]; // [R3]
			if (wr_div_lo) divisor_ff <= {div_hi_tmp_ff, wbyte}; // [R3] [R2]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff      <= CTRL_RST;
			irq_msk_ff   <= EV_RST;
			gen_armed_ff <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl_ff <= wbyte;
			if (wr_irq_msk) irq_msk_ff <= wbyte[EV_W-1:0];
			// armed once for good: clearing the enables later does not stop it
			if (ctrl_ff[CTRL_TX_ON] || ctrl_ff[CTRL_RX_ON]) gen_armed_ff <= 1'b1; // [R5]
		end
	end

	// ---------------- transmit buffer
	wire tx_load = ctrl_ff[CTRL_TX_ON] && gen_run && !tx_busy && !tx_buffer_empty_flag_ff;
	wire tx_bit_end = tk.tick16 && (tx_rt_ff == RT_LAST);
	wire tx_done = tx_busy && tx_bit_end && (bits_left_ff == 4'h1);
	wire nine = ctrl_ff[CTRL_NINE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ninth_ff   <= 1'b0;
			data_lo_ff <= 8'h00;
			tx_buffer_empty_flag_ff    <= 1'b1;
		end else begin
			if (wr_data_hi) ninth_ff <= wbyte[0];
			if (wr_data_lo) data_lo_ff <= wbyte;
			// a new character written while the old one leaves keeps the buffer full
			if (wr_data_lo) tx_buffer_empty_flag_ff <= 1'b0; // [R11]
			else if (tx_load) tx_buffer_empty_flag_ff <= 1'b1; // [R12]
		end
	end

	// ---------------- transmit shifter
	// frame word, lsb out first: start, data, optional ninth bit, stop
	wire [10:0] frame = nine ? {1'b1, ninth_ff, data_lo_ff, 1'b0} // [R9]
		: {2'b11, data_lo_ff, 1'b0}; // [R10] [R15]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_ff  <= TX_IDLE;
			shift_ff     <= 11'h7ff;
			bits_left_ff <= 4'h0;
			tx_rt_ff     <= 4'h0;
		end else begin
			case (tx_state_ff)
				TX_IDLE: begin
					if (tx_load) begin // [R10]
						tx_state_ff  <= TX_SHIFT;
						shift_ff     <= frame;
						bits_left_ff <= nine ? BITS_9 : BITS_8; // [R8]
						tx_rt_ff     <= 4'h0;
					end
				end
				TX_SHIFT: begin
					if (tk.tick16) tx_rt_ff <= tx_rt_ff + 4'h1; // [R1] [R7]
					if (tx_bit_end) begin
						shift_ff     <= {1'b1, shift_ff[10:1]}; // [R15]
						bits_left_ff <= bits_left_ff - 4'h1;
						if (bits_left_ff == 4'h1) tx_state_ff <= TX_IDLE;
					end
				end
				default: tx_state_ff <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) txd_ff <= 1'b1;
		else txd_ff <= tx_busy ? shift_ff[0] : 1'b1; // [R15]
	end

	assign txd = txd_ff;

	// ---------------- receive pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_meta_ff <= 1'b1;
			rxd_sync_ff <= 1'b1;
		end else begin
			rxd_meta_ff <= rxd;
			rxd_sync_ff <= rxd_meta_ff;
		end
	end

	// ---------------- interrupts
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] nxt_irq_st;

	always_comb begin
		events             = '0;
		events[EV_TX_BUFFER_EMPTY_FLAG]    = tx_load;
		events[EV_TX_DONE] = tx_done;
		events[EV_START]   = rx_found;
		events[EV_REJECT]  = rx_rejected;
		events[EV_NOISE]   = rx_noise; // [R14]
		// a set in the clearing cycle survives
		nxt_irq_st = (irq_st_ff & ~(wr_irq_st ? wbyte[EV_W-1:0] : EV_RST)) | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) irq_st_ff <= EV_RST;
		else irq_st_ff <= nxt_irq_st;
	end

	assign irq = |(irq_st_ff & irq_msk_ff);

	// ---------------- shared baud generator and receiver front end
	sbt_baud u_baud (
		.aclk    (aclk),
		.aresetn (aresetn),
		.divisor (divisor_ff),
		.run     (gen_run),
		.tk      (tk.gen)
	); // [R7]

	sbt_rx_start u_rx (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.enable      (ctrl_ff[CTRL_RX_ON] && gen_run),
		.nine        (nine),
		.rxd         (rxd_sync_ff),
		.tk          (tk.user),
		.start_found (rx_found),
		.rejected    (rx_rejected),
		.noise_hit   (rx_noise),
		.busy        (rx_busy)
	); // [R13] [R16]
endmodule : sbt_top

// ---- sbt_chk_assertions.sv ----
// port-level assertions for the serial transmitter top
`timescale 1ns/1ps
module sbt_chk
	import sbt_pkg::*;
#(
	parameter int AW = AXI_AW
) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic          txd,
	input wire logic          irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	// only word-aligned offsets up to the data low buffer decode
	wire wr_unmap = (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr > OFF_DATA_LO);
	wire rd_wonly = (s_axi_araddr == OFF_DATA_HI) || (s_axi_araddr == OFF_DATA_LO);
	a_reset_idle: assert property ($rose(aresetn) |-> txd && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("line or bus not idle after reset");
	a_start_min: assert property ($fell(txd) |-> !txd [*8])
		else $error("start bit too short");
	// the write is performed the cycle after both are taken, the response one edge later
	a_write_resp: assert property (wr_both |-> ##2 s_axi_bvalid)
		else $error("no write response after address and data");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_unmap_err: assert property (wr_both && wr_unmap |-> ##2 s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	a_read_resp: assert property (rd_take |=> s_axi_rvalid)
		else $error("no read data after address");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	a_data_wonly: assert property (rd_take && rd_wonly |=> s_axi_rdata == 32'h0)
		else $error("data buffer readable");
	a_aw_block: assert property (s_axi_awvalid && s_axi_awready && !(s_axi_wvalid && s_axi_wready) |=> !s_axi_awready)
		else $error("second write address accepted");
	c_write: cover property (wr_both);
	c_frame: cover property ($fell(txd));
	c_irq: cover property ($rose(irq));
endmodule : sbt_chk

bind sbt_top sbt_chk #(.AW(AW)) chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd, .irq);

// ---- sbt_remote.sv ----
// remote serial device: decodes frames on txd and drives rxd
`timescale 1ns/1ps
module sbt_remote #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic aclk,
	input  wire logic txd,
	input  wire logic nine,
	output logic      rxd
);
	logic [9:0] got[$];
	logic [8:0] d;
	logic       ok;
	initial rxd = 1'b1;
	// sampled mid-bit on the falling edge, clear of the edge that launches txd
	always begin
		@(negedge aclk);
		if (txd === 1'b0) begin
			d = 9'h0;
			repeat (BIT_CLKS / 2) @(negedge aclk);
			ok = (txd === 1'b0);
			for (int i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (BIT_CLKS) @(negedge aclk);
				d[i] = txd;
			end
			repeat (BIT_CLKS) @(negedge aclk);
			ok = ok && (txd === 1'b1);
			got.push_back({ok, d});
		end
	end
	task automatic glitch(input int n);
		@(posedge aclk);
		rxd <= 1'b0;
		repeat (n) @(posedge aclk);
		rxd <= 1'b1;
	endtask : glitch
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge aclk);
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CLKS) @(posedge aclk);
		end
	endtask : send
endmodule : sbt_remote

// ---- testbench.sv ----
// self-checking bench for the serial transmitter top
`timescale 1ns/1ps
module testbench;
	import sbt_pkg::*;
	localparam int DIV  = 2;
	localparam int BITC = 16 * DIV;
	logic        aclk = 1'b0, aresetn = 1'b0, nine = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, b;
	logic [31:0] wdata = 32'h0, rdata, dd;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, txd, rxd, irq, b8, n9;
	int          err_count = 0, tests_run = 0;
	always #2.5 aclk = ~aclk;
	sbt_top #(.AW(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txd, .rxd, .irq);
	sbt_remote #(.BIT_CLKS(BITC)) remote_u (.aclk, .txd, .nine, .rxd);
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tmo(input bit hit);
		if (hit) begin
			err_count++;
			$display("MISMATCH wait expected answer seen none");
			results();
		end
	endtask : tmo
	// ready is sampled on the falling edge; nothing in the design moves between it and the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		bit ta, tw;
		n = 0;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw) && n < 100) begin
			@(negedge aclk);
			ta = ta || (awvalid && awready);
			tw = tw || (wvalid && wready);
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end
		do begin
			@(negedge aclk);
			n++;
		end while (bvalid !== 1'b1 && n < 200);
		rs = bresp;
		tmo(n >= 200);
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 100);
		@(posedge aclk);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < 200);
		d = rdata;
		rs = rresp;
		tmo(n >= 200);
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] rs;
		wr(a, d, rs);
		chk("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
	endtask : w
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  rs;
		rd(a, d, rs);
		chk(nm, d, e);
	endtask : rc
	task automatic get_frame(input logic [9:0] e);
		int n;
		n = 0;
		while (remote_u.got.size() == 0 && n < 5000) begin
			@(posedge aclk);
			n++;
		end
		tmo(n >= 5000);
		chk("frame", {22'h0, remote_u.got.pop_front()}, {22'h0, e});
	endtask : get_frame
	initial begin
		void'($urandom(8939));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc("div_hi", OFF_DIV_HI, 32'h0);
		rc("ctrl", OFF_CTRL, 32'h0);
		rc("status", OFF_STAT, 32'h1);
		rc("data_lo", OFF_DATA_LO, 32'h0);
		rd(8'h20, dd, r);
		chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		chk("rdata", dd, 32'h0);
		wr(8'h22, 32'h1, r);
		chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test reset done");
		w(OFF_DIV_HI, 32'h1f);
		rc("div_hi", OFF_DIV_HI, 32'h0);
		w(OFF_DIV_LO, 32'h02);
		rc("div_hi", OFF_DIV_HI, 32'h1f);
		rc("div_lo", OFF_DIV_LO, 32'h02);
		w(OFF_DIV_HI, 32'h0);
		w(OFF_DIV_LO, 32'(DIV));
		rc("status", OFF_STAT, 32'h1);
		w(OFF_CTRL, 32'h3);
		rc("status", OFF_STAT, 32'h9);
		w(OFF_DIV_LO, 32'h0);
		rc("status", OFF_STAT, 32'h1);
		w(OFF_DIV_LO, 32'(DIV));
		$display("test divisor done");
		for (int k = 0; k < 6; k++) begin
			n9 = k[0];
			b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			b8 = 1'($urandom);
			nine <= n9;
			w(OFF_CTRL, {27'h0, n9, 4'h3});
			w(OFF_DATA_HI, {31'h0, b8});
			w(OFF_DATA_LO, {24'h0, b});
			get_frame({1'b1, n9 & b8, b});
		end
		repeat (BITC) @(posedge aclk);
		w(OFF_IRQ_MSK, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		rc("irq_st", OFF_IRQ_ST, 32'h3);
		w(OFF_IRQ_MSK, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		w(OFF_IRQ_ST, 32'h3);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test transmit done");
		w(OFF_CTRL, 32'h3);
		nine <= 1'b0;
		w(OFF_DATA_LO, 32'ha5);
		w(OFF_DATA_LO, 32'h5a);
		rc("status", OFF_STAT, 32'ha);
		get_frame(10'h2a5);
		get_frame(10'h25a);
		$display("test back to back done");
		// let the last stop bit end so its done event is not left behind the clear
		repeat (BITC) @(posedge aclk);
		w(OFF_IRQ_ST, 32'h1f);
		remote_u.glitch(3);
		repeat (60) @(posedge aclk);
		rc("irq_st", OFF_IRQ_ST, 32'h08);
		w(OFF_IRQ_ST, 32'h1f);
		// low through the third and fifth samples only: confirmed start with noise
		remote_u.glitch(10);
		repeat (11 * BITC) @(posedge aclk);
		rc("irq_st", OFF_IRQ_ST, 32'h14);
		w(OFF_IRQ_ST, 32'h1f);
		fork
			remote_u.send(8'h96);
			begin
				w(OFF_DATA_LO, 32'h3c);
				get_frame(10'h23c);
			end
		join
		repeat (BITC) @(posedge aclk);
		rc("irq_st", OFF_IRQ_ST, 32'h07);
		$display("test receive done");
		results();
	end
endmodule : testbench
